// ===== design/fsp_ctrl.sv
// Purpose: control, status, baud, gap and framing of the fast serial port
// Assumes: register port with one-cycle strobes, read data one cycle later
// Notes: single-byte transmit holding register, eight-byte receive buffer
`include "fsp_defs.svh"
`default_nettype none
module fsp_ctrl #(
   parameter int RX_DEPTH = 8
) (
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic [15:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   output logic TXD,
   input wire logic RXD,
   output logic RTS,
   input wire logic CTS,
   output logic RX_INTR,
   output logic DONE_INTR
);
   fsp_pkg::fsp_ctl_t ctl_q;
   logic [12:0] baud_q;
   logic [7:0] gap_q;
   logic txdone_q, rxdone_q, ovf_q, xoff_q;
   logic [7:0] hold_q;
   logic hold_full_q;
   logic [9:0] txcnt_q, rxcnt_q;
   logic tx_blk_q, rx_blk_q;
   fsp_pkg::fsp_st_t tx_st_q, rx_st_q;
   logic [12:0] tx_bc_q, rx_bc_q;
   logic [7:0] tx_sh_q, rx_sh_q;
   logic [2:0] tx_bit_q, rx_bit_q;
   logic [7:0] tx_stop_q;
   logic [7:0] rx_mem_q [RX_DEPTH];
   logic [2:0] rx_wp_q, rx_rp_q;
   logic [3:0] rx_n_q;

   function automatic logic sticky(input logic cur, input logic set, input logic clr);
      // a hardware set in the same cycle as a software clear wins
      sticky = set | (cur & ~clr);
   endfunction

   logic wr_ctl, wr_data, rd_data;
   logic cts_act, stall, tx_take, tx_fin, rx_fin, rx_flow, rx_push, rx_pop;
   logic rx_full, rx_any, tx_rdy;
   logic [7:0] stop_bits;
   assign wr_ctl = WR && ADDR == `FSP_A_CTL;
   assign wr_data = WR && ADDR == `FSP_A_DATA;
   assign rd_data = RD && ADDR == `FSP_A_DATA;
   assign rx_full = rx_n_q == 4'(RX_DEPTH);
   assign rx_any = rx_n_q != 4'h0;
   assign tx_rdy = ~hold_full_q;
   assign cts_act = CTS ^ ctl_q.cts_pol;
   assign stall = (ctl_q.cts_en & ~cts_act) | (ctl_q.xoff_en & xoff_q);
   assign tx_take = tx_st_q == fsp_pkg::ST_IDLE && hold_full_q && !stall;
   assign tx_fin = tx_st_q == fsp_pkg::ST_STOP && tx_bc_q == 13'h0 && tx_stop_q == 8'h0;
   assign rx_fin = rx_st_q == fsp_pkg::ST_STOP && rx_bc_q == 13'h0;
   // flow characters are consumed, not stored
   assign rx_flow = ctl_q.xoff_en && (rx_sh_q == `FSP_XON || rx_sh_q == `FSP_XOFF);
   assign rx_push = rx_fin && RXD && !rx_flow;
   assign rx_pop = rd_data && rx_any;
   // gap overrides stop select in block mode
   assign stop_bits = tx_blk_q ? ((gap_q > `FSP_GAP_BIAS + 8'h1) ? gap_q - `FSP_GAP_BIAS : 8'h1)
                               : (ctl_q.one_stop ? 8'h1 : 8'h2);

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ctl_q <= '0;
      end else if (wr_ctl) begin
         ctl_q.en <= WDATA[`FSP_B_EN];
         ctl_q.rts_pol <= WDATA[`FSP_B_RTSP];
         ctl_q.cts_pol <= WDATA[`FSP_B_CTSP];
         ctl_q.xoff_en <= WDATA[`FSP_B_XOFFEN];
         ctl_q.cts_en <= WDATA[`FSP_B_CTSEN];
         ctl_q.rie <= WDATA[`FSP_B_RIE];
         ctl_q.die <= WDATA[`FSP_B_DIE];
         ctl_q.one_stop <= WDATA[`FSP_B_ONESTOP];
         ctl_q.pms <= WDATA[`FSP_B_PMS];
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         baud_q <= `FSP_BAUD_RST;
         gap_q <= `FSP_GAP_RST;
      end else if (WR && ADDR == `FSP_A_BAUD) begin
         baud_q <= WDATA[12:0];
      end else if (WR && ADDR == `FSP_A_GAP) begin
         gap_q <= WDATA[7:0];
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         txdone_q <= 1'b0;
         rxdone_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         txdone_q <= sticky(txdone_q, tx_fin && tx_blk_q && txcnt_q == 10'h0,
                            wr_ctl && WDATA[`FSP_B_TXDONE]);
         rxdone_q <= sticky(rxdone_q, rx_push && rx_blk_q && rxcnt_q == 10'h0,
                            wr_ctl && WDATA[`FSP_B_RXDONE]);
         ovf_q <= sticky(ovf_q, rx_push && rx_full && !rx_pop, wr_ctl && WDATA[`FSP_B_OVF]);
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         xoff_q <= 1'b0;
      end else if (rx_fin && RXD && rx_flow) begin
         xoff_q <= rx_sh_q == `FSP_XOFF;
      end
   end

   // data write loads the holding register
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         hold_q <= 8'h0;
         hold_full_q <= 1'b0;
      end else if (wr_data && !hold_full_q) begin
         hold_q <= WDATA[7:0];
         hold_full_q <= 1'b1;
      end else if (tx_take && ctl_q.en) begin
         hold_full_q <= 1'b0;
      end
   end

   // block counters run down and park at all ones
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         txcnt_q <= 10'h0;
         tx_blk_q <= 1'b0;
      end else if (WR && ADDR == `FSP_A_TXCNT) begin
         txcnt_q <= WDATA[9:0];
         tx_blk_q <= 1'b1;
      end else if (tx_fin && tx_blk_q) begin
         txcnt_q <= txcnt_q - 10'h1;
         tx_blk_q <= txcnt_q != 10'h0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         rxcnt_q <= 10'h0;
         rx_blk_q <= 1'b0;
      end else if (WR && ADDR == `FSP_A_RXCNT) begin
         rxcnt_q <= WDATA[9:0];
         rx_blk_q <= 1'b1;
      end else if (rx_push && rx_blk_q) begin
         rxcnt_q <= rxcnt_q - 10'h1;
         rx_blk_q <= rxcnt_q != 10'h0;
      end
   end

   // transmitter, idle line high while disabled
   always_ff @(posedge MCLK) begin
      if (SRST || !ctl_q.en) begin
         tx_st_q <= fsp_pkg::ST_IDLE;
         tx_bc_q <= 13'h0;
         tx_sh_q <= 8'h0;
         tx_bit_q <= 3'h0;
         tx_stop_q <= 8'h0;
         TXD <= 1'b1;
      end else begin
         unique case (tx_st_q)
            fsp_pkg::ST_IDLE: begin
               TXD <= 1'b1;
               if (tx_take) begin
                  tx_sh_q <= hold_q;
                  tx_bc_q <= baud_q;
                  tx_st_q <= fsp_pkg::ST_START;
                  TXD <= 1'b0;
               end
            end
            fsp_pkg::ST_START: begin
               if (tx_bc_q == 13'h0) begin
                  tx_bc_q <= baud_q;
                  tx_bit_q <= 3'h0;
                  TXD <= tx_sh_q[0];
                  tx_st_q <= fsp_pkg::ST_DATA;
               end else begin
                  tx_bc_q <= tx_bc_q - 13'h1;
               end
            end
            fsp_pkg::ST_DATA: begin
               if (tx_bc_q == 13'h0) begin
                  tx_bc_q <= baud_q;
                  tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                  tx_bit_q <= tx_bit_q + 3'h1;
                  if (tx_bit_q == 3'h7) begin
                     TXD <= 1'b1;
                     tx_stop_q <= stop_bits - 8'h1;
                     tx_st_q <= fsp_pkg::ST_STOP;
                  end else begin
                     TXD <= tx_sh_q[1];
                  end
               end else begin
                  tx_bc_q <= tx_bc_q - 13'h1;
               end
            end
            fsp_pkg::ST_STOP: begin
               TXD <= 1'b1;
               if (tx_bc_q != 13'h0) begin
                  tx_bc_q <= tx_bc_q - 13'h1;
               end else if (tx_stop_q != 8'h0) begin
                  tx_stop_q <= tx_stop_q - 8'h1;
                  tx_bc_q <= baud_q;
               end else begin
                  tx_st_q <= fsp_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // receiver samples mid-bit and needs just one stop
   always_ff @(posedge MCLK) begin
      if (SRST || !ctl_q.en) begin
         rx_st_q <= fsp_pkg::ST_IDLE;
         rx_bc_q <= 13'h0;
         rx_sh_q <= 8'h0;
         rx_bit_q <= 3'h0;
      end else begin
         unique case (rx_st_q)
            fsp_pkg::ST_IDLE: begin
               if (!RXD) begin
                  rx_bc_q <= {1'b0, baud_q[12:1]};
                  rx_st_q <= fsp_pkg::ST_START;
               end
            end
            fsp_pkg::ST_START: begin
               if (rx_bc_q != 13'h0) begin
                  rx_bc_q <= rx_bc_q - 13'h1;
               end else if (RXD) begin
                  // glitch shorter than half a bit, not a start
                  rx_st_q <= fsp_pkg::ST_IDLE;
               end else begin
                  rx_bc_q <= baud_q;
                  rx_bit_q <= 3'h0;
                  rx_st_q <= fsp_pkg::ST_DATA;
               end
            end
            fsp_pkg::ST_DATA: begin
               if (rx_bc_q != 13'h0) begin
                  rx_bc_q <= rx_bc_q - 13'h1;
               end else begin
                  rx_bc_q <= baud_q;
                  rx_sh_q <= {RXD, rx_sh_q[7:1]};
                  rx_bit_q <= rx_bit_q + 3'h1;
                  if (rx_bit_q == 3'h7) begin
                     rx_st_q <= fsp_pkg::ST_STOP;
                  end
               end
            end
            fsp_pkg::ST_STOP: begin
               if (rx_bc_q != 13'h0) begin
                  rx_bc_q <= rx_bc_q - 13'h1;
               end else begin
                  // framing error drops the character silently
                  rx_st_q <= fsp_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // receive buffer, overflow byte is lost
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         rx_wp_q <= 3'h0;
         rx_rp_q <= 3'h0;
         rx_n_q <= 4'h0;
      end else begin
         if (rx_push && (!rx_full || rx_pop)) begin
            rx_mem_q[rx_wp_q] <= rx_sh_q;
            rx_wp_q <= rx_wp_q + 3'h1;
         end
         if (rx_pop) begin
            rx_rp_q <= rx_rp_q + 3'h1;
         end
         if (rx_push && !rx_full && !rx_pop) begin
            rx_n_q <= rx_n_q + 4'h1;
         end else if (rx_pop && !rx_push) begin
            rx_n_q <= rx_n_q - 4'h1;
         end
      end
   end

   // request-to-send asks for data while room remains
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         RTS <= 1'b0;
         RX_INTR <= 1'b0;
         DONE_INTR <= 1'b0;
      end else begin
         RTS <= (ctl_q.cts_en & ctl_q.en & ~rx_full) ^ ctl_q.rts_pol;
         RX_INTR <= ctl_q.rie & (ctl_q.pms ? rx_full : rx_any);
         DONE_INTR <= ctl_q.die & (txdone_q | rxdone_q);
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         RDATA <= 16'h0;
      end else if (RD) begin
         unique case (ADDR)
            `FSP_A_CTL: RDATA <= {ctl_q.en, ctl_q.rts_pol, ctl_q.cts_pol, xoff_q,
                                  ctl_q.xoff_en, ctl_q.cts_en, ctl_q.rie, ctl_q.die,
                                  txdone_q, rxdone_q, ctl_q.one_stop, tx_rdy,
                                  ctl_q.pms, ovf_q, rx_full, rx_any};
            `FSP_A_BAUD: RDATA <= {3'h0, baud_q};
            `FSP_A_GAP: RDATA <= {8'h0, gap_q};
            `FSP_A_DATA: RDATA <= {8'h0, rx_mem_q[rx_rp_q]};
            `FSP_A_RXCNT: RDATA <= {6'h0, rxcnt_q};
            `FSP_A_TXCNT: RDATA <= {6'h0, txcnt_q};
            default: RDATA <= 16'h0;
         endcase
      end else begin
         RDATA <= 16'h0;
      end
   end

   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);

   a_port_disable: assert property (!ctl_q.en |=> tx_st_q == fsp_pkg::ST_IDLE && TXD)
      else $error("transmitter active while port disabled");
   a_rts_polarity: assert property (ctl_q.rts_pol && !ctl_q.cts_en |=> RTS)
      else $error("request-to-send not idle at inverted polarity");
   a_cts_gate: assert property (ctl_q.cts_en && !(CTS ^ ctl_q.cts_pol) && tx_st_q == fsp_pkg::ST_IDLE
      |=> tx_st_q == fsp_pkg::ST_IDLE)
      else $error("transmit started without clear-to-send");
   a_xoff_catch: assert property (rx_fin && RXD && ctl_q.xoff_en && rx_sh_q == 8'h13 |=> xoff_q)
      else $error("received XOFF not recorded");
   a_xoff_pause: assert property (ctl_q.xoff_en && xoff_q && tx_st_q == fsp_pkg::ST_IDLE
      |=> tx_st_q == fsp_pkg::ST_IDLE)
      else $error("transmit started during XOFF");
   a_done_sticky: assert property (txdone_q && !(wr_ctl && WDATA[7]) |=> txdone_q)
      else $error("transmit done flag lost");
   a_ovf_sticky: assert property (ovf_q && !(wr_ctl && WDATA[2]) |=> ovf_q)
      else $error("overflow flag lost");
   a_full_status: assert property (RD && ADDR == 16'hc070 |=> RDATA[1] == $past(rx_n_q == 4'h8)
      && RDATA[0] == $past(rx_n_q != 4'h0))
      else $error("buffer status bits wrong");
   a_tx_ready: assert property (wr_data && tx_rdy |=> !tx_rdy)
      else $error("transmit ready stayed high after load");
   a_start_low: assert property (ctl_q.en && tx_st_q == fsp_pkg::ST_IDLE && tx_take ##1 ctl_q.en
      |-> !TXD [*2])
      else $error("start bit not low");
   a_rx_intr: assert property (ctl_q.rie && !ctl_q.pms && rx_any |=> RX_INTR)
      else $error("receive interrupt missing");
   a_rxdone_sticky: assert property (rxdone_q && !(wr_ctl && WDATA[`FSP_B_RXDONE]) |=> rxdone_q)
      else $error("receive done flag lost");
   a_rts_off: assert property (!ctl_q.cts_en |=> RTS == $past(ctl_q.rts_pol))
      else $error("request-to-send active with hardware flow off");
   a_done_mask: assert property (!ctl_q.die |=> !DONE_INTR)
      else $error("done interrupt not masked");

   c_byte_sent: cover property (tx_fin);
   c_block_tx: cover property (tx_fin && tx_blk_q && txcnt_q == 10'h0);
   c_block_rx: cover property (rx_push && rx_blk_q && rxcnt_q == 10'h0);
   c_xoff: cover property ($rose(xoff_q));
   c_overflow: cover property ($rose(ovf_q));
endmodule
`default_nettype wire

// ===== design/fsp_defs.svh
// Purpose: constants of the fast serial port control block
// Assumes: 16-bit register port, byte-wide serial characters
// Notes: offsets are byte addresses as seen by the cpu
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH
`define FSP_A_CTL 16'hc070
`define FSP_A_BAUD 16'hc072
`define FSP_A_GAP 16'hc074
`define FSP_A_DATA 16'hc076
`define FSP_A_RXCNT 16'hc07a
`define FSP_A_TXCNT 16'hc07e
`define FSP_B_EN 15
`define FSP_B_RTSP 14
`define FSP_B_CTSP 13
`define FSP_B_XOFF 12
`define FSP_B_XOFFEN 11
`define FSP_B_CTSEN 10
`define FSP_B_RIE 9
`define FSP_B_DIE 8
`define FSP_B_TXDONE 7
`define FSP_B_RXDONE 6
`define FSP_B_ONESTOP 5
`define FSP_B_TXRDY 4
`define FSP_B_PMS 3
`define FSP_B_OVF 2
`define FSP_B_FULL 1
`define FSP_B_RXRDY 0
`define FSP_BAUD_RST 13'h0017
`define FSP_GAP_RST 8'h09
`define FSP_GAP_BIAS 8'h07
`define FSP_CNT_DONE 10'h3ff
`define FSP_XON 8'h11
`define FSP_XOFF 8'h13
`endif

// ===== design/fsp_pkg.sv
// Purpose: types of the fast serial port control block
// Assumes: nothing beyond the defs header
// Notes: state codes are one-hot
`default_nettype none
package fsp_pkg;
   typedef struct packed {
      logic en;
      logic rts_pol;
      logic cts_pol;
      logic xoff_en;
      logic cts_en;
      logic rie;
      logic die;
      logic one_stop;
      logic pms;
   } fsp_ctl_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_START = 4'h2,
      ST_DATA = 4'h4,
      ST_STOP = 4'h8
   } fsp_st_t;
endpackage
`default_nettype wire

// ===== tb/fsp_peer.sv
// Purpose: serial peer on the far side of the fast serial port
// Assumes: line idles high, bit time counted in MCLK cycles
// Notes: start stamps let the bench measure the stop time between characters
`default_nettype none
module fsp_peer (
   input wire logic clk,
   input wire logic txd,
   output logic rxd,
   output logic cts
);
   timeunit 1ns;
   timeprecision 1ns;
   int bc = 24;
   int cyc = 0;
   logic [7:0] rx_q[$];
   int st_q[$];
   logic [7:0] mb;
   logic cts_lvl = 1'b1;
   initial rxd = 1'b1;
   assign cts = cts_lvl;
   always @(posedge clk) cyc <= cyc + 1;
   task automatic send(input logic [7:0] b, input int ns);
      rxd <= 1'b0;
      repeat (bc) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         rxd <= b[i];
         repeat (bc) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (bc * ns) @(posedge clk);
   endtask
   initial forever begin
      @(negedge txd);
      st_q.push_back(cyc);
      repeat (bc / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (bc) @(posedge clk);
         mb[i] = txd;
      end
      repeat (bc) @(posedge clk);
      if (txd) rx_q.push_back(mb);
   end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: self-checking bench of the fast serial port control
// Assumes: reset divisor, so one bit lasts 24 cycles
// Notes: data bytes come from an lfsr with a fixed seed
`include "fsp_defs.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic MCLK = 1'b0;
   logic SRST = 1'b1;
   logic [15:0] ADDR = 16'h0000;
   logic [15:0] WDATA = 16'h0000;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [15:0] RDATA;
   logic TXD, RXD, RTS, CTS, RX_INTR, DONE_INTR;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] seed = 32'hdd3576da;
   logic [15:0] v;
   logic [7:0] exp_q[$];
   fsp_ctrl #(.RX_DEPTH(8)) u_dut (.MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .TXD(TXD), .RXD(RXD), .RTS(RTS), .CTS(CTS), .RX_INTR(RX_INTR), .DONE_INTR(DONE_INTR));
   fsp_peer u_peer (.clk(MCLK), .txd(TXD), .rxd(RXD), .cts(CTS));
   initial forever #20 MCLK = ~MCLK;
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // a hang counts as a mismatch; the whole run needs about 6400 cycles
   always @(posedge MCLK) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         err_count++;
         results();
      end
   end
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction
   function automatic logic rts_exp(input logic pol, input logic act);
      return pol ? ~act : act;
   endfunction
   function automatic int stops(input logic blk, input logic one, input logic [7:0] gap);
      if (blk) return (gap > 8'h08) ? int'(gap) - 7 : 1;
      return one ? 1 : 2;
   endfunction
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkp(input string n, input logic e, input logic g);
      chk(n, {15'h0000, e}, {15'h0000, g});
   endtask
   // second edge keeps back-to-back calls from assigning a strobe twice at one edge
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
      @(posedge MCLK);
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 d = RDATA;
      @(posedge MCLK);
   endtask
   task automatic wait_bit(input int b, input logic val);
      for (int i = 0; i < 400; i++) begin
         rd(`FSP_A_CTL, v);
         if (v[b] === val) break;
      end
      chkp("wait ready", val, v[b]);
   endtask
   task automatic wait_tx(input int n);
      for (int i = 0; i < 1000 && u_peer.rx_q.size() < n; i++) @(posedge MCLK);
      chk("wait tx", 16'(n), 16'(u_peer.rx_q.size()));
   endtask
   initial begin
      int d;
      int e;
      logic [7:0] b;
      repeat (20) @(posedge MCLK);
      SRST <= 1'b0;
      @(posedge MCLK);
      rd(`FSP_A_CTL, v);
      chk("ctl", 16'h0000, v & 16'hffef);
      rd(`FSP_A_BAUD, v);
      chk("baud", 16'h0017, v);
      rd(`FSP_A_GAP, v);
      chk("gap", 16'h0009, v);
      rd(16'hc078, v);
      chk("unmapped", 16'h0000, v);
      wr(`FSP_A_BAUD, 16'h1387);
      rd(`FSP_A_BAUD, v);
      chk("baud", 16'h1387, v);
      wr(`FSP_A_BAUD, 16'h0017);
      u_peer.send(8'ha5, 1);
      rd(`FSP_A_CTL, v);
      chk("rx off", 16'h0000, v & 16'h0001);
      chkp("rts", rts_exp(1'b0, 1'b0), RTS);
      $display("test registers done");
      wr(`FSP_A_GAP, 16'h000a);
      for (int m = 0; m < 3; m++) begin
         wr(`FSP_A_CTL, m == 0 ? 16'h8120 : 16'h8100);
         if (m == 2) wr(`FSP_A_TXCNT, 16'h0001);
         u_peer.st_q.delete();
         u_peer.rx_q.delete();
         exp_q.delete();
         for (int k = 0; k < 2; k++) begin
            wait_bit(4, 1'b1);
            exp_q.push_back(rnd());
            wr(`FSP_A_DATA, {8'h00, exp_q[k]});
         end
         rd(`FSP_A_CTL, v);
         chk("tx ready", 16'h0000, v & 16'h0010);
         wait_tx(2);
         repeat (100) @(posedge MCLK);
         for (int k = 0; k < 2; k++) chk("tx byte", {8'h00, exp_q[k]}, {8'h00, u_peer.rx_q[k]});
         d = u_peer.st_q[1] - u_peer.st_q[0];
         e = 24 * (9 + stops(m == 2, m == 0, 8'h0a));
         chk("frame", 16'(e), (d >= e && d <= e + 2) ? 16'(e) : 16'(d));
         chkp("done intr", m == 2, DONE_INTR);
      end
      rd(`FSP_A_TXCNT, v);
      chk("tx count", 16'h03ff, v);
      wr(`FSP_A_CTL, 16'h8000);
      repeat (2) @(posedge MCLK);
      chkp("done mask", 1'b0, DONE_INTR);
      wr(`FSP_A_CTL, 16'h8080);
      rd(`FSP_A_CTL, v);
      chk("tx done", 16'h0000, v & 16'h0080);
      $display("test transmit done");
      wr(`FSP_A_CTL, 16'h8608);
      repeat (2) @(posedge MCLK);
      chkp("rts", rts_exp(1'b0, 1'b1), RTS);
      exp_q.delete();
      for (int k = 0; k < 9; k++) begin
         b = rnd();
         if (k < 8) exp_q.push_back(b);
         u_peer.send(b, 1 + k % 2);
         if (k == 0) chkp("rx intr", 1'b0, RX_INTR);
      end
      repeat (4) @(posedge MCLK);
      rd(`FSP_A_CTL, v);
      chk("ctl", 16'h860f, v & 16'hffef);
      chkp("rx intr", 1'b1, RX_INTR);
      chkp("rts", rts_exp(1'b0, 1'b0), RTS);
      wr(`FSP_A_CTL, 16'hc408);
      repeat (2) @(posedge MCLK);
      chkp("rx intr", 1'b0, RX_INTR);
      chkp("rts", rts_exp(1'b1, 1'b0), RTS);
      rd(`FSP_A_CTL, v);
      chk("ctl", 16'hc40f, v & 16'hffef);
      wr(`FSP_A_CTL, 16'h8204);
      for (int k = 0; k < 8; k++) begin
         rd(`FSP_A_DATA, v);
         chk("rx byte", {8'h00, exp_q[k]}, {8'h00, v[7:0]});
      end
      rd(`FSP_A_CTL, v);
      chk("ctl", 16'h8200, v & 16'hffef);
      chkp("rx intr", 1'b0, RX_INTR);
      wr(`FSP_A_CTL, 16'h8100);
      wr(`FSP_A_RXCNT, 16'h0000);
      u_peer.send(rnd(), 2);
      repeat (4) @(posedge MCLK);
      chkp("done intr", 1'b1, DONE_INTR);
      rd(`FSP_A_RXCNT, v);
      chk("rx count", 16'h03ff, v);
      wr(`FSP_A_CTL, 16'h8140);
      rd(`FSP_A_CTL, v);
      chk("rx done", 16'h0000, v & 16'h0040);
      $display("test receive done");
      for (int k = 0; k < 2; k++) begin
         u_peer.rx_q.delete();
         wr(`FSP_A_CTL, k == 0 ? 16'h8800 : 16'ha400);
         if (k == 0) u_peer.send(8'h13, 1);
         b = rnd();
         wr(`FSP_A_DATA, {8'h00, b});
         repeat (400) @(posedge MCLK);
         chk("stall", 16'h0000, 16'(u_peer.rx_q.size()));
         rd(`FSP_A_CTL, v);
         chk("xoff", k == 0 ? 16'h1000 : 16'h0000, v & 16'h1000);
         if (k == 0) u_peer.send(8'h11, 1);
         else u_peer.cts_lvl <= 1'b0;
         wait_tx(1);
         chk("tx byte", {8'h00, b}, {8'h00, u_peer.rx_q[0]});
      end
      $display("test flow control done");
      results();
   end
endmodule
`default_nettype wire
